//--- hdl/pcie_phy_rx_detect_config.sv
// Per-port physical layer configuration bank and lane detect control
`timescale 1ns/1ps
`include "phy_cfg_map.svh"

module pcie_phy_rx_detect_config (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ee_wr_i,
	input wire logic [1:0] ee_port_i,
	input wire logic [7:0] ee_addr_i,
	input wire logic [31:0] ee_data_i,
	input wire logic smb_wr_i,
	input wire logic [1:0] smb_port_i,
	input wire logic [7:0] smb_addr_i,
	input wire logic [31:0] smb_data_i,
	input wire logic i2c_wr_i,
	input wire logic [1:0] i2c_port_i,
	input wire logic [7:0] i2c_addr_i,
	input wire logic [31:0] i2c_data_i,
	input wire logic rd_i,
	input wire logic [1:0] rd_port_i,
	input wire logic [7:0] rd_addr_i,
	output logic [31:0] rd_data_o,
	output logic rd_valid_o,
	input wire phy_cfg_pkg::lane_vec_t rx_det_req_i,
	input wire phy_cfg_pkg::lane_vec_t rx_above_i,
	input wire phy_cfg_pkg::lane_vec_t phy_err_i,
	output phy_cfg_pkg::lane_vec_t rx_det_busy_o,
	output phy_cfg_pkg::lane_vec_t rx_det_done_o,
	output phy_cfg_pkg::lane_vec_t rx_det_present_o,
	output phy_cfg_pkg::sdt_vec_t sig_det_thr_o,
	output phy_cfg_pkg::nib_vec_t rx_eq_o,
	output phy_cfg_pkg::nib_vec_t tx_idle_lat_o,
	output phy_cfg_pkg::lane_vec_t tx_half_swing_o,
	output phy_cfg_pkg::lane_vec_t tx_deemph_en_o,
	output phy_cfg_pkg::trim_vec_t tx_deemph_ofs_o,
	output phy_cfg_pkg::trim_vec_t tx_amp_ofs_o
);
	import phy_cfg_pkg::*;

	// ----------------------------------------
	// Write source merge
	// ----------------------------------------
	logic wr_en;
	logic [1:0] wr_port;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;

	// Same-cycle clash: EEPROM, then SMBus, then I2C
	always_comb begin
		wr_en = 1'b1;
		wr_port = i2c_port_i;
		wr_addr = i2c_addr_i;
		wr_data = i2c_data_i;
		if (ee_wr_i) begin
			wr_port = ee_port_i;
			wr_addr = ee_addr_i;
			wr_data = ee_data_i;
		end else if (smb_wr_i) begin
			wr_port = smb_port_i;
			wr_addr = smb_addr_i;
			wr_data = smb_data_i;
		end else if (!i2c_wr_i) begin
			wr_en = 1'b0;
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [`NUM_PORTS-1:0][31:0] pp2, next_pp2;
	logic [`NUM_LANES-1:0][9:0] trim, next_trim;
	lane_vec_t err, next_err;
	logic [31:0] next_rd_data;
	logic next_rd_valid;
	logic [31:0] stat_word;

	always_comb begin
		next_pp2 = pp2;
		next_trim = trim;
		next_err = err;
		for (int p = 0; p < `NUM_PORTS; p++) begin
			if (wr_en && wr_port == 2'(p) && wr_addr == `PP2_OFS) begin
				next_pp2[p] = wr_data;
			end
		end
		for (int l = 0; l < `NUM_LANES; l++) begin
			if (wr_en && wr_port == 2'(l / `LPP) &&
			    wr_addr[7:4] == `TRIM_HI &&
			    wr_addr[3:2] == 2'(l % `LPP)) begin
				next_trim[l] = wr_data[9:0];
			end
			if (wr_en && wr_port == 2'(l / `LPP) &&
			    wr_addr == `STAT_OFS &&
			    wr_data[`ST_ERR_LSB + l % `LPP]) begin
				next_err[l] = 1'b0;
			end
			// Set after clear, so a fresh error is never lost
			if (phy_err_i[l]) begin
				next_err[l] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		stat_word = 32'h0000_0000;
		for (int k = 0; k < `LPP; k++) begin
			if (rd_port_i < 2'(`NUM_PORTS)) begin
				stat_word[`ST_PRES_LSB + k] =
					rx_det_present_o[int'(rd_port_i) * `LPP + k];
				stat_word[`ST_ERR_LSB + k] =
					err[int'(rd_port_i) * `LPP + k];
				stat_word[`ST_BUSY_LSB + k] =
					rx_det_busy_o[int'(rd_port_i) * `LPP + k];
			end
		end
		next_rd_valid = rd_i;
		next_rd_data = 32'h0000_0000;
		if (rd_i && rd_port_i < 2'(`NUM_PORTS)) begin
			if (rd_addr_i == `PP2_OFS) begin
				next_rd_data = pp2[rd_port_i];
			end else if (rd_addr_i == `STAT_OFS) begin
				next_rd_data = stat_word;
			end else if (rd_addr_i[7:4] == `TRIM_HI &&
			             rd_addr_i[1:0] == 2'h0) begin
				next_rd_data = {22'h00_0000,
					trim[int'(rd_port_i) * `LPP + int'(rd_addr_i[3:2])]};
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pp2 <= {`NUM_PORTS{`PP2_RESET}};
			trim <= {`NUM_LANES{`TRIM_RESET}};
			err <= 12'h000;
			rd_data_o <= 32'h0000_0000;
			rd_valid_o <= 1'b0;
		end else begin
			pp2 <= next_pp2;
			trim <= next_trim;
			err <= next_err;
			rd_data_o <= next_rd_data;
			rd_valid_o <= next_rd_valid;
		end
	end

	// ----------------------------------------
	// Per-lane controls and detection
	// ----------------------------------------
	// Packet routing and the elastic buffer sit in the datapath, not here;
	// each port's bank drives only that port's four lanes.
	for (genvar l = 0; l < `NUM_LANES; l++) begin : g_lane
		localparam int P = l / `LPP;

		rx_detect_timer u_det (
			.core_clk_i(core_clk_i),
			.reset_i(reset_i),
			.start_i(rx_det_req_i[l]),
			.wait_code_i(pp2[P][`DETW_MSB:`DETW_LSB]),
			.above_i(rx_above_i[l]),
			.busy_o(rx_det_busy_o[l]),
			.done_o(rx_det_done_o[l]),
			.present_o(rx_det_present_o[l])
		);

		assign sig_det_thr_o[l] = pp2[P][`SDT_MSB:`SDT_LSB];
		assign rx_eq_o[l] = pp2[P][`REQ_MSB:`REQ_LSB];
		assign tx_idle_lat_o[l] = pp2[P][`LAT_MSB:`LAT_LSB];
		assign tx_half_swing_o[l] = pp2[P][`SWING_BIT];
		assign tx_deemph_en_o[l] = !pp2[P][`SWING_BIT];
		// Offset only matters while de-emphasis is applied
		assign tx_deemph_ofs_o[l] = pp2[P][`SWING_BIT] ? 5'h00 :
			trim[l][`DEO_MSB:`DEO_LSB];
		assign tx_amp_ofs_o[l] = trim[l][`AMO_MSB:`AMO_LSB];
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence ee_pp2_wr_s;
		ee_wr_i && ee_port_i == 2'h0 && ee_addr_i == `PP2_OFS;
	endsequence
	sequence smb_only_wr_s;
		smb_wr_i && !ee_wr_i && smb_port_i == 2'h1 &&
		smb_addr_i == `PP2_OFS;
	endsequence
	sequence det_start_s;
		rx_det_req_i[0] && !rx_det_busy_o[0] &&
		pp2[0][`DETW_MSB:`DETW_LSB] == 3'h0;
	endsequence

	ee_write_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		ee_pp2_wr_s |=> pp2[0] == $past(ee_data_i))
		else $error("EEPROM write not stored");
	smb_write_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		smb_only_wr_s |=> pp2[1] == $past(smb_data_i))
		else $error("SMBus write not stored");
	detect_wait_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		det_start_s ##1 !rx_det_done_o[0] [*8] |->
		##18 rx_det_done_o[0])
		else $error("shortest detect wait wrong length");
	swing_deemph_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		tx_deemph_en_o[5] != pp2[1][`SWING_BIT] &&
		tx_half_swing_o[5] == pp2[1][`SWING_BIT])
		else $error("swing and de-emphasis disagree");
	sig_thr_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		sig_det_thr_o[9] == pp2[2][`SDT_MSB:`SDT_LSB])
		else $error("threshold not taken from port field");
	err_sticky_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		phy_err_i[2] |=> err[2])
		else $error("lane error flag lost");
	read_valid_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		rd_i && rd_port_i == 2'h0 && rd_addr_i == `PP2_OFS
		&& !wr_en |=> rd_valid_o && rd_data_o == pp2[0])
		else $error("register read mismatch");
	half_no_ofs_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		tx_half_swing_o[5] |-> tx_deemph_ofs_o[5] == 5'h00)
		else $error("offset applied in half swing");
endmodule

//--- hdl/phy_cfg_map.svh
// Register offsets, field positions, reset values and wait times
`ifndef PHY_CFG_MAP_SVH
`define PHY_CFG_MAP_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define NUM_PORTS 3
`define NUM_LANES 12
`define LPP 4

// ----------------------------------------
// Offsets
// ----------------------------------------
`define PP2_OFS 8'h7C
`define STAT_OFS 8'h80
`define TRIM_HI 4'hC

// ----------------------------------------
// Second physical parameter register fields
// ----------------------------------------
`define PP2_RESET 32'h0190_0020
`define LAT_MSB 3
`define LAT_LSB 0
`define DETW_MSB 6
`define DETW_LSB 4
`define SDT_MSB 21
`define SDT_LSB 20
`define REQ_MSB 25
`define REQ_LSB 22
`define SWING_BIT 30

// ----------------------------------------
// Lane trim and status fields
// ----------------------------------------
`define TRIM_RESET 10'h000
`define DEO_MSB 4
`define DEO_LSB 0
`define AMO_MSB 9
`define AMO_LSB 5
`define ST_PRES_LSB 0
`define ST_ERR_LSB 4
`define ST_BUSY_LSB 8

// ----------------------------------------
// Receiver detection waits, microseconds
// ----------------------------------------
`define CLK_MHZ 25
`define DETW_US0 1
`define DETW_US1 2
`define DETW_US2 4
`define DETW_US3 5
`define DETW_US4 10
`define DETW_US5 20
`define DETW_US6 40
`define DETW_US7 50
`define DETW_CYC(us) ((us) * `CLK_MHZ)

`endif

//--- hdl/phy_cfg_pkg.sv
// Types shared by the physical layer configuration logic
package phy_cfg_pkg;
	typedef enum logic {DET_IDLE, DET_WAIT} det_state_t;
	typedef logic [11:0] lane_vec_t;
	typedef logic [11:0][1:0] sdt_vec_t;
	typedef logic [11:0][3:0] nib_vec_t;
	typedef logic [11:0][4:0] trim_vec_t;
endpackage

//--- hdl/rx_detect_timer.sv
// One lane's receiver detection wait and decision
`timescale 1ns/1ps
`include "phy_cfg_map.svh"

module rx_detect_timer (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire logic [2:0] wait_code_i,
	input wire logic above_i,
	output logic busy_o,
	output logic done_o,
	output logic present_o
);
	import phy_cfg_pkg::*;

	det_state_t state, next_state;
	logic [10:0] cnt, next_cnt;
	logic [10:0] load;
	logic next_done, next_present;

	always_comb begin
		unique case (wait_code_i)
		3'h0: load = 11'(`DETW_CYC(`DETW_US0) - 1);
		3'h1: load = 11'(`DETW_CYC(`DETW_US1) - 1);
		3'h2: load = 11'(`DETW_CYC(`DETW_US2) - 1);
		3'h3: load = 11'(`DETW_CYC(`DETW_US3) - 1);
		3'h4: load = 11'(`DETW_CYC(`DETW_US4) - 1);
		3'h5: load = 11'(`DETW_CYC(`DETW_US5) - 1);
		3'h6: load = 11'(`DETW_CYC(`DETW_US6) - 1);
		3'h7: load = 11'(`DETW_CYC(`DETW_US7) - 1);
		endcase
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_done = 1'b0;
		next_present = present_o;
		unique case (state)
		DET_IDLE: begin
			// Code is latched at start; later edits do not stretch a wait
			if (start_i) begin
				next_cnt = load;
				next_state = DET_WAIT;
			end
		end
		DET_WAIT: begin
			if (cnt == 11'h000) begin
				next_done = 1'b1;
				next_present = above_i;
				next_state = DET_IDLE;
			end else begin
				next_cnt = cnt - 11'h001;
			end
		end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= DET_IDLE;
			cnt <= 11'h000;
			done_o <= 1'b0;
			present_o <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			done_o <= next_done;
			present_o <= next_present;
		end
	end

	assign busy_o = (state == DET_WAIT);

	start_busy_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		start_i && !busy_o |=> busy_o)
		else $error("detect wait did not start");
	decide_sample_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		done_o |-> present_o == $past(above_i) && !busy_o)
		else $error("decision not taken from line level");
	done_pulse_a: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		done_o |=> !done_o)
		else $error("done held longer than one cycle");
endmodule

//--- verif/link_partner_model.sv
// Link partner termination model seen by the receiver detect probe
`timescale 1ns/1ps

module link_partner_model
	import phy_cfg_pkg::*;
(
	input wire logic core_clk_i,
	input wire phy_cfg_pkg::lane_vec_t term_i,
	input wire phy_cfg_pkg::lane_vec_t busy_i,
	output phy_cfg_pkg::lane_vec_t above_o
);
	lane_vec_t junk = 12'hA5A;

	// No probe running: line level means nothing, so keep it moving
	always @(posedge core_clk_i) junk <= ~junk;
	assign above_o = (busy_i & term_i) | (~busy_i & junk);
endmodule

//--- verif/pcie_phy_rx_detect_config_tb_top.sv
// Self-checking bench for the physical layer configuration bank
`timescale 1ns/1ps
`include "phy_cfg_map.svh"

`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end

module pcie_phy_rx_detect_config_tb_top;
	import phy_cfg_pkg::*;
	logic core_clk_i = 0;
	logic reset_i = 1;
	logic rd_i = 0;
	logic rd_valid_o;
	logic [2:0] wr_en = 0;
	logic [1:0] wp = 0, rp = 0;
	logic [7:0] wa = 0, ra = 0;
	logic [31:0] wd = 0, v, d, ev, rd_data_o;
	lane_vec_t req = 0, err = 0, term = 0, above, busy, done, pres, half, dem;
	sdt_vec_t sdt;
	nib_vec_t eq, idl;
	trim_vec_t dofs, aofs;
	integer seed = 32'h5E08, n_fail = 0, cmp_count = 0, cyc = 0, n;
	int lat[8] = '{1, 2, 4, 5, 10, 20, 40, 50};
	logic [31:0] expq[$];

	initial forever #20 core_clk_i = ~core_clk_i;

	pcie_phy_rx_detect_config i_dut (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .ee_wr_i(wr_en[0]), .ee_port_i(wp),
		.ee_addr_i(wa), .ee_data_i(wd), .smb_wr_i(wr_en[1]),
		.smb_port_i(wp), .smb_addr_i(wa), .smb_data_i(wd),
		.i2c_wr_i(wr_en[2]), .i2c_port_i(wp), .i2c_addr_i(wa),
		.i2c_data_i(wd), .rd_i(rd_i), .rd_port_i(rp), .rd_addr_i(ra),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.rx_det_req_i(req), .rx_above_i(above), .phy_err_i(err),
		.rx_det_busy_o(busy), .rx_det_done_o(done),
		.rx_det_present_o(pres), .sig_det_thr_o(sdt), .rx_eq_o(eq),
		.tx_idle_lat_o(idl), .tx_half_swing_o(half), .tx_deemph_en_o(dem),
		.tx_deemph_ofs_o(dofs), .tx_amp_ofs_o(aofs));

	link_partner_model i_partner (.core_clk_i(core_clk_i), .term_i(term),
		.busy_i(busy), .above_o(above));

	task tally_and_finish;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task wr(input int s, input logic [1:0] p, input logic [7:0] a,
		input logic [31:0] x);
		wp = p; wa = a; wd = x; wr_en = 3'h1 << s;
		@(posedge core_clk_i); #1 wr_en = 0;
		@(posedge core_clk_i); #1;
	endtask

	task rdc(input logic [1:0] p, input logic [7:0] a, input logic [31:0] e);
		rp = p; ra = a; rd_i = 1; expq.push_back(e);
		@(posedge core_clk_i); #1 rd_i = 0;
		@(posedge core_clk_i); #1;
	endtask

	// Scoreboard: one queued note per read, taken off in issue order
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end else if (rd_valid_o === 1'b1) begin
			ev = expq.size() > 0 ? expq.pop_front() : 32'hDEAD_BEEF;
			`CHK("rd_data", ev, rd_data_o)
		end
	end

	initial begin
		repeat (16) @(posedge core_clk_i);
		#1 reset_i = 0;
		rdc(0, `PP2_OFS, `PP2_RESET);
		`CHK("sdt0", 2'h1, sdt[0])
		`CHK("eq0", 4'h6, eq[0])
		`CHK("dem0", 1'h1, dem[0])
		// Every wait code, written by the three sources in turn
		for (int k = 0; k < 8; k++) begin
			v = `PP2_RESET;
			v[6:4] = 3'(k);
			wr(k % 3, 0, `PP2_OFS, v);
			term = 12'($random(seed));
			req[0] = 1;
			@(posedge core_clk_i); #1 req[0] = 0;
			n = 0;
			while (done[0] !== 1'b1 && n < 2000) begin
				@(posedge core_clk_i); #1 n++;
			end
			`CHK("det_cyc", lat[k] * `CLK_MHZ, n)
			`CHK("present", term[0], pres[0])
		end
		v = $random(seed);
		v[30] = 1;
		wr(0, 1, `PP2_OFS, ~v);
		wr(1, 1, `PP2_OFS, v);
		rdc(1, `PP2_OFS, v);
		`CHK("half4", 1'h1, half[4])
		`CHK("dem4", 1'h0, dem[4])
		`CHK("half3", 1'h0, half[3])
		`CHK("sdt7", v[21:20], sdt[7])
		`CHK("eq5", v[25:22], eq[5])
		`CHK("idl6", v[3:0], idl[6])
		d = $random(seed);
		wr(2, 1, {`TRIM_HI, 4'h4}, d);
		`CHK("dofs5h", 5'h00, dofs[5])
		`CHK("aofs5", d[9:5], aofs[5])
		v[30] = 0;
		wr(2, 1, `PP2_OFS, v);
		`CHK("dofs5", d[4:0], dofs[5])
		`CHK("dem5", 1'h1, dem[5])
		err[2] = 1;
		@(posedge core_clk_i); #1 err[2] = 0;
		@(posedge core_clk_i); #1;
		rdc(0, `STAT_OFS, {24'h0, 4'h4, 3'h0, term[0]});
		wr(1, 0, `STAT_OFS, 32'h40);
		rdc(0, `STAT_OFS, {31'h0, term[0]});
		// Error event and its clear on one edge: the event must survive
		err[2] = 1;
		wp = 0;
		wa = `STAT_OFS;
		wd = 32'h40;
		wr_en = 3'h2;
		@(posedge core_clk_i);
		#1 err[2] = 0;
		wr_en = 0;
		@(posedge core_clk_i);
		#1;
		rdc(0, `STAT_OFS, {24'h0, 4'h4, 3'h0, term[0]});
		rdc(2'h3, `PP2_OFS, 32'h0);
		rdc(0, 8'h44, 32'h0);
		repeat (3) @(posedge core_clk_i);
		`CHK("rd_left", 0, expq.size())
		tally_and_finish();
	end
endmodule
